// ===== scf_pkg.sv
// Constants, register map and carrier types for the system clock, standby and interrupt flag block.
// Assumes one 125 MHz clock that is also the main oscillator clock, and an APB master with 32-bit data.
//
// Function
// R1: Two-bit rate select: 0 divides by 32 (reset), 1 undivided, 2 halves, 3 unusable.
// R2: A new clock rate takes effect within 64 main oscillator cycles of the write.
// R3: Software waits out the clock switching time before issuing halt.
// R4: Oscillator stop bit resets to 0; writing 1 stops the main clock.
// R5: Halt with deep sleep select at 0 enters the light halt mode.
// R6: Halt ends on reset, enabled wake pin, enabled interrupt release, or time-base overflow.
// R7: Halt with deep sleep select at 1 enters the deep hold mode.
// R8: Hold ends only on reset or a high wake pin with hold pin wake enabled.
// R9: Software places exactly one no-operation right before the halt entering hold.
// R10: Software sets hold pin wake and the time-base source before entering hold.
// R11: With the watchdog option, a missed time-base flag clear causes a watchdog reset.
// R12: Time-base flag already set at halt: overflow ends halt and fires watchdog reset.
// R13: Software clears the time-base flag or enables its interrupt wake before halt.
// R14: Five enable bits, each set or cleared alone, never several at once.
// R15: Enable bits clear at reset and when hold mode is entered.
// R16: Enable bits never clear on their own after interrupt service.
// R17: Request flags clear by writing 0; writing 1 keeps them; software never sets.
// R18: At reset all request flags clear except the timer 1 flag.
// R19: The serial request flag clears when a serial transfer starts.
// R20: All request flags clear when hold mode is entered; the code keeps set a flag whose event arrives in the hold entry cycle.
// R21: Software clears each flag itself, only with its enable or master enable off.
// R22: Software uses whole-word writes on the flag register, never single bit operations.
// R23: After a standby ends without reset, execution resumes with the clock rate kept.

package scf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CLKCTL = 12'h000;
  localparam logic [11:0] ADDR_STBCTL = 12'h004;
  localparam logic [11:0] ADDR_IEN = 12'h008;
  localparam logic [11:0] ADDR_IRQF = 12'h00C;
  localparam logic [11:0] ADDR_CMD = 12'h010;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CMD_HALT_POS = 0;
  localparam int IENW_VAL_POS = 4;
  localparam int IEN_MASTER_POS = 8;
  localparam logic [3:0] IEN_MASTER_IDX = 4'h8;
  localparam int IRQ_N = 5;
  localparam int IRQ_EXT0 = 0;
  localparam int IRQ_EXT1 = 1;
  localparam int IRQ_TBASE = 2;
  localparam int IRQ_TMR1 = 3;
  localparam int IRQ_SER = 4;
  localparam logic [IRQ_N-1:0] IRQ_FLAG_RST = 5'h08;

  // ----------------------------------------------------------------
  // Clock rate codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_DIV32 = 2'h0;
  localparam logic [1:0] RATE_DIV1 = 2'h1;
  localparam logic [1:0] RATE_DIV2 = 2'h2;
  localparam logic [1:0] RATE_BAD = 2'h3;
  localparam logic [4:0] DIV_WRAP = 5'h1F;
  localparam int SWITCH_MAX_OSC = 64;
  localparam int SWITCH_MAX_CYC = SWITCH_MAX_OSC;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_HALT = 2'h1,
    ST_HOLD = 2'h2
  } scf_state_t;

  typedef struct packed {
    logic [1:0] active_rate;
    logic switch_pending;
    logic main_osc_stop;
    logic [1:0] clock_rate_select;
  } scf_clk_t;

  typedef struct packed {
    logic halt_irq_wake_enable;
    logic halt_pin_wake_enable;
    logic hold_pin_wake_enable;
    logic deep_sleep_select;
  } scf_stb_t;

endpackage

// ===== scf_flag.sv
// One hardware-set, software-cleared request flag with a chosen reset value.
// Assumes set and clear are single-cycle terms from the same clock domain.
`timescale 1ns/100ps
`default_nettype none

module scf_flag #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic set,
  input wire logic clr,
  // State
  output logic q
);

  logic q_r;
  logic q_nxt;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_comb begin
    q_nxt = set | (q_r & ~clr);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= RST_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

`default_nettype wire

// ===== scf_top.sv
// System clock rate, oscillator stop, standby modes, watchdog and interrupt flags behind an APB slave.
// Assumes pclk is the main oscillator clock and all event inputs are synchronous one-cycle pulses or levels.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module scf_top (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wake and events
  input wire logic wake_pin,
  input wire logic irq_release,
  input wire logic timebase_overflow,
  input wire logic [1:0] ext_irq,
  input wire logic timer1_event,
  input wire logic serial_done,
  input wire logic serial_start,
  input wire logic watchdog_option,
  // Clock and standby
  output logic sys_clk_en,
  output logic [1:0] active_rate,
  output logic main_osc_stop,
  output logic halt_mode,
  output logic hold_mode,
  output logic wake_event,
  output logic watchdog_reset,
  // Interrupts
  output logic [4:0] irq_enable,
  output logic master_enable,
  output logic [4:0] irq_flags,
  output logic irq_request
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  scf_pkg::scf_state_t state_r, state_nxt;
  scf_pkg::scf_clk_t clk_r, clk_nxt;
  scf_pkg::scf_stb_t stb_r, stb_nxt;
  logic [4:0] div_r, div_nxt;
  logic [4:0] ien_r, ien_nxt;
  logic mst_r, mst_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic sclk_r, sclk_nxt;
  logic wake_r, wake_nxt;
  logic wdt_r, wdt_nxt;
  logic irq_r, irq_nxt;
  logic [scf_pkg::IRQ_N-1:0] flag_q, flag_set, flag_clr;
  logic wr, hit_clk, hit_stb, hit_ien, hit_irqf, hit_cmd, mapped;
  logic halt_cmd, enter_hold, halt_exit, hold_exit, tick;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  always_comb begin
    hit_clk = paddr == scf_pkg::ADDR_CLKCTL;
    hit_stb = paddr == scf_pkg::ADDR_STBCTL;
    hit_ien = paddr == scf_pkg::ADDR_IEN;
    hit_irqf = paddr == scf_pkg::ADDR_IRQF;
    hit_cmd = paddr == scf_pkg::ADDR_CMD;
    mapped = hit_clk | hit_stb | hit_ien | hit_irqf | hit_cmd;
    wr = psel & penable & pready_r & pwrite & mapped;
    halt_cmd = wr & hit_cmd & pwdata[scf_pkg::CMD_HALT_POS] & (state_r == scf_pkg::ST_RUN);
    enter_hold = halt_cmd & stb_r.deep_sleep_select;
    halt_exit = (wake_pin & stb_r.halt_pin_wake_enable) | (irq_release & stb_r.halt_irq_wake_enable)
                | timebase_overflow; // R6
    hold_exit = wake_pin & stb_r.hold_pin_wake_enable; // R8
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, data and error registered
  // ----------------------------------------------------------------
  always_comb begin
    pready_nxt = psel & penable & ~pready_r;
    pslverr_nxt = psel & penable & ~pready_r & ~mapped;
    prdata_nxt = 32'h0000_0000;
    if (psel & penable & ~pready_r & ~pwrite) begin
      if (hit_clk) begin
        prdata_nxt[5:0] = clk_r;
      end
      if (hit_stb) begin
        prdata_nxt[3:0] = stb_r;
      end
      if (hit_ien) begin
        prdata_nxt[4:0] = ien_r;
        prdata_nxt[scf_pkg::IEN_MASTER_POS] = mst_r;
      end
      if (hit_irqf) begin
        prdata_nxt[4:0] = flag_q;
      end
      if (hit_cmd) begin
        prdata_nxt[1:0] = state_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock rate and divider
  // ----------------------------------------------------------------
  always_comb begin
    clk_nxt = clk_r;
    div_nxt = div_r + 5'h01;
    if (wr & hit_clk) begin
      clk_nxt.main_osc_stop = pwdata[2]; // R4
      if (pwdata[1:0] != scf_pkg::RATE_BAD) begin
        clk_nxt.clock_rate_select = pwdata[1:0]; // R1
        clk_nxt.switch_pending = 1'b1;
      end
    end
    // The switch lands on a divide-by-32 boundary, at most 32 cycles away.
    if (clk_r.switch_pending & (div_r == scf_pkg::DIV_WRAP)) begin
      clk_nxt.active_rate = clk_nxt.clock_rate_select; // R2
      clk_nxt.switch_pending = 1'b0;
    end
    unique case (clk_r.active_rate)
      scf_pkg::RATE_DIV1: tick = 1'b1;
      scf_pkg::RATE_DIV2: tick = div_r[0];
      default: tick = div_r == scf_pkg::DIV_WRAP;
    endcase
    sclk_nxt = (state_r == scf_pkg::ST_RUN) & ~clk_r.main_osc_stop & tick; // R4 R23
  end

  // ----------------------------------------------------------------
  // Standby control and mode sequencing
  // ----------------------------------------------------------------
  always_comb begin
    stb_nxt = stb_r;
    state_nxt = state_r;
    wake_nxt = 1'b0;
    if (wr & hit_stb) begin
      stb_nxt = pwdata[3:0];
    end
    unique case (state_r)
      scf_pkg::ST_RUN: begin
        if (halt_cmd) begin
          state_nxt = stb_r.deep_sleep_select ? scf_pkg::ST_HOLD : scf_pkg::ST_HALT; // R5 R7
        end
      end
      scf_pkg::ST_HALT: begin
        if (halt_exit) begin
          state_nxt = scf_pkg::ST_RUN; // R6 R23
          wake_nxt = 1'b1;
        end
      end
      scf_pkg::ST_HOLD: begin
        if (hold_exit) begin
          state_nxt = scf_pkg::ST_RUN; // R8 R23
          wake_nxt = 1'b1;
        end
      end
      default: state_nxt = scf_pkg::ST_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // Interrupt enables, flags, watchdog
  // ----------------------------------------------------------------
  always_comb begin
    ien_nxt = ien_r;
    mst_nxt = mst_r;
    if (wr & hit_ien) begin
      // Each write touches exactly one bit; other indices are ignored.
      if (pwdata[3:0] < 4'(scf_pkg::IRQ_N)) begin
        ien_nxt[pwdata[2:0]] = pwdata[scf_pkg::IENW_VAL_POS]; // R14 R16
      end else if (pwdata[3:0] == scf_pkg::IEN_MASTER_IDX) begin
        mst_nxt = pwdata[scf_pkg::IENW_VAL_POS];
      end
    end
    if (enter_hold) begin
      ien_nxt = 5'h00; // R15
    end
    flag_set = '0;
    flag_set[scf_pkg::IRQ_EXT0] = ext_irq[0];
    flag_set[scf_pkg::IRQ_EXT1] = ext_irq[1];
    flag_set[scf_pkg::IRQ_TBASE] = timebase_overflow;
    flag_set[scf_pkg::IRQ_TMR1] = timer1_event;
    flag_set[scf_pkg::IRQ_SER] = serial_done;
    flag_clr = {scf_pkg::IRQ_N{enter_hold}}; // R20
    if (wr & hit_irqf) begin
      flag_clr = flag_clr | ~pwdata[4:0]; // R17
    end
    flag_clr[scf_pkg::IRQ_SER] = flag_clr[scf_pkg::IRQ_SER] | serial_start; // R19
    wdt_nxt = watchdog_option & timebase_overflow & flag_q[scf_pkg::IRQ_TBASE]; // R11 R12
    irq_nxt = mst_r & |(flag_q & ien_r);
  end

  genvar gi;
  generate
    for (gi = 0; gi < scf_pkg::IRQ_N; gi++) begin : g_flag
      scf_flag #(
        .RST_VAL(scf_pkg::IRQ_FLAG_RST[gi]) // R18
      ) u_flag (
        .pclk(pclk),
        .presetn(presetn),
        .set(flag_set[gi]),
        .clr(flag_clr[gi]),
        .q(flag_q[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= scf_pkg::ST_RUN;
      clk_r <= '{active_rate: scf_pkg::RATE_DIV32, switch_pending: 1'b0, main_osc_stop: 1'b0,
                 clock_rate_select: scf_pkg::RATE_DIV32};
      stb_r <= '0;
      div_r <= 5'h00;
      ien_r <= 5'h00;
      mst_r <= 1'b0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      sclk_r <= 1'b0;
      wake_r <= 1'b0;
      wdt_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      clk_r <= clk_nxt;
      stb_r <= stb_nxt;
      div_r <= div_nxt;
      ien_r <= ien_nxt;
      mst_r <= mst_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      sclk_r <= sclk_nxt;
      wake_r <= wake_nxt;
      wdt_r <= wdt_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sys_clk_en = sclk_r;
  assign active_rate = clk_r.active_rate;
  assign main_osc_stop = clk_r.main_osc_stop;
  assign halt_mode = state_r[0];
  assign hold_mode = state_r[1];
  assign wake_event = wake_r;
  assign watchdog_reset = wdt_r;
  assign irq_enable = ien_r;
  assign master_enable = mst_r;
  assign irq_flags = flag_q;
  assign irq_request = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [6:0] sw_cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_cnt_r <= 7'h00;
    end else begin
      sw_cnt_r <= clk_r.switch_pending ? sw_cnt_r + 7'h01 : 7'h00;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_BAD_RATE_IGNORED: assert property ( // R1
    (wr & hit_clk & (pwdata[1:0] == scf_pkg::RATE_BAD)) |=> clk_r.clock_rate_select == $past(clk_r.clock_rate_select))
    else $error("Unusable clock rate code was accepted.");
  AST_SWITCH_BOUND: assert property ( // R2
    sw_cnt_r < 7'(scf_pkg::SWITCH_MAX_CYC))
    else $error("Clock rate switch took longer than its bound.");
  AST_OSC_STOP_GATES: assert property ( // R4
    clk_r.main_osc_stop |=> !sys_clk_en)
    else $error("System clock enable ran with the oscillator stopped.");
  AST_HALT_ENTRY: assert property ( // R5
    (halt_cmd & !stb_r.deep_sleep_select) |=> halt_mode ##1 (halt_mode || wake_event))
    else $error("Halt command did not enter halt mode.");
  AST_HALT_EXIT: assert property ( // R6
    (halt_mode & halt_exit) |=> !halt_mode && wake_event && !sys_clk_en)
    else $error("Halt mode did not end on a wake cause.");
  AST_HOLD_ENTRY: assert property ( // R7
    (halt_cmd & stb_r.deep_sleep_select) |=> hold_mode)
    else $error("Halt command did not enter hold mode.");
  AST_HOLD_STAYS: assert property ( // R8
    (hold_mode & !hold_exit) |=> hold_mode)
    else $error("Hold mode ended without a pin wake.");
  AST_HOLD_CLEARS: assert property ( // R15 R20
    (enter_hold & (flag_set == '0)) |=> (irq_enable == 5'h00) && (irq_flags == 5'h00))
    else $error("Hold entry left enables or flags set.");
  AST_WDT_CAUSE: assert property ( // R12
    watchdog_reset |-> $past(watchdog_option & timebase_overflow & flag_q[scf_pkg::IRQ_TBASE]))
    else $error("Watchdog reset fired without a missed time-base clear.");
  AST_NO_SW_SET: assert property ( // R17
    ((irq_flags & ~$past(irq_flags) & ~$past(flag_set)) == 5'h00))
    else $error("A request flag rose without its event.");
  AST_SERIAL_CLR: assert property ( // R19
    (serial_start & !serial_done) |=> !irq_flags[scf_pkg::IRQ_SER])
    else $error("Serial flag survived a transfer start.");
  AST_IEN_SINGLE: assert property ( // R14
    !$past(enter_hold) |-> $countones(irq_enable ^ $past(irq_enable)) <= 1)
    else $error("Several enable bits changed at once.");

  COV_HALT: cover property (halt_cmd & !stb_r.deep_sleep_select ##1 halt_mode ##[1:50] wake_event);
  COV_HOLD: cover property (enter_hold ##1 hold_mode ##[1:50] wake_event);
  COV_WDT: cover property (watchdog_reset);
  COV_SWITCH: cover property (clk_r.switch_pending ##1 !clk_r.switch_pending);

endmodule

`default_nettype wire

// ===== test_sysclk_standby_irq_flags.sv
// Self-checking testbench for the clock rate, standby and interrupt flag block.
// Assumes scf_top and scf_pkg are compiled first; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none

module test_sysclk_standby_irq_flags;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wake_pin = 1'b0;
  logic irq_release = 1'b0;
  logic watchdog_option = 1'b0;
  logic [5:0] ev = 6'h00;
  logic wake_event;
  logic watchdog_reset;
  logic sys_clk_en;
  logic [1:0] active_rate;
  logic main_osc_stop;
  logic halt_mode;
  logic hold_mode;
  logic [4:0] irq_enable;
  logic master_enable;
  logic [4:0] irq_flags;
  logic irq_request;
  logic tk_on = 1'b0;
  int tk_q[$];
  int n_tick = 0;
  logic [32:0] rd_q[$];
  logic wk_q[$];
  logic [31:0] seed = 32'hD020;
  logic [4:0] ef = 5'h08;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;

  always #4 pclk = ~pclk;

  scf_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_pin(wake_pin), .irq_release(irq_release), .timebase_overflow(ev[2]),
    .ext_irq(ev[1:0]), .timer1_event(ev[3]), .serial_done(ev[4]), .serial_start(ev[5]),
    .watchdog_option(watchdog_option), .sys_clk_en(sys_clk_en), .active_rate(active_rate),
    .main_osc_stop(main_osc_stop), .halt_mode(halt_mode), .hold_mode(hold_mode), .wake_event(wake_event),
    .watchdog_reset(watchdog_reset), .irq_enable(irq_enable), .master_enable(master_enable),
    .irq_flags(irq_flags), .irq_request(irq_request)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20) begin
      n_fail++;
      $display("wrong value pready expected 1 seen %b", pready);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic pulse(input logic [5:0] v);
    @(posedge pclk);
    ev <= v;
    @(posedge pclk);
    ev <= 6'h00;
  endtask

  // Counts system clock ticks over a 64-cycle window; the monitor compares the count.
  task automatic ticks(input int e);
    tk_on <= 1'b1;
    repeat (64) @(posedge pclk);
    tk_on <= 1'b0;
    tk_q.push_back(e);
  endtask

  task automatic wait_wake(input logic wd);
    int k;
    k = 0;
    wk_q.push_back(wd);
    while (wake_event !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    if (k == 50) begin
      n_fail++;
      $display("wrong value wake_event expected 1 seen %b", wake_event);
    end
    wake_pin <= 1'b0;
    irq_release <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  always @(posedge pclk) begin
    logic [32:0] e;
    e = 33'h0;
    if (tk_on) begin
      n_tick += (sys_clk_en === 1'b1);
    end else if (tk_q.size() > 0) begin
      cmp("sys_clk_en", 33'(tk_q.pop_front()), 33'(n_tick));
      n_tick = 0;
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rd_q.size() == 0) begin
        n_fail++;
        $display("wrong value prdata expected none seen %h", prdata);
      end else begin
        e = rd_q.pop_front();
        cmp("prdata", e, {pslverr, prdata});
        if (paddr == scf_pkg::ADDR_CLKCTL) begin
          cmp("active_rate", {30'h0, e[5:4], e[2]}, {30'h0, active_rate, main_osc_stop});
        end
        if (paddr == scf_pkg::ADDR_IRQF) begin
          cmp("irq_flags", {28'h0, e[4:0]}, {28'h0, irq_flags});
        end
        if (paddr == scf_pkg::ADDR_IEN) begin
          cmp("irq_enable", {27'h0, e[8], e[4:0]}, {27'h0, master_enable, irq_enable});
          cmp("irq_request", {32'h0, e[8] & |(e[4:0] & ef)}, {32'h0, irq_request});
        end
        if (paddr == scf_pkg::ADDR_CMD) begin
          cmp("halt_mode", {31'h0, e[1:0]}, {31'h0, hold_mode, halt_mode});
        end
      end
    end
    if (wake_event === 1'b1) begin
      if (wk_q.size() == 0) begin
        n_fail++;
        $display("wrong value wake_event expected 0 seen 1");
      end else begin
        cmp("watchdog_reset", {32'h0, wk_q.pop_front()}, {32'h0, watchdog_reset});
        cmp("standby_mode", 33'h0, {31'h0, hold_mode, halt_mode});
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0] rates[4];
    logic [1:0] cur;
    logic [31:0] ee;
    logic [4:0] m;
    logic [31:0] d;
    rates = '{2'h1, 2'h3, 2'h0, 2'h2};
    cur = 2'h0;
    ee = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(scf_pkg::ADDR_CLKCTL, 33'h0);
    rd(scf_pkg::ADDR_IRQF, 33'h08);
    rd(scf_pkg::ADDR_IEN, 33'h0);
    rd(12'h014, {1'b1, 32'h0});
    $display("test reset done");
    foreach (rates[i]) begin
      apb(1'b1, scf_pkg::ADDR_CLKCTL, {30'h0, rates[i]});
      if (rates[i] != scf_pkg::RATE_BAD) cur = rates[i];
      repeat (scf_pkg::SWITCH_MAX_OSC) @(posedge pclk);
      rd(scf_pkg::ADDR_CLKCTL, {27'h0, cur, 2'h0, cur});
      ticks((cur == scf_pkg::RATE_DIV1) ? 64 : (cur == scf_pkg::RATE_DIV2) ? 32 : 2);
    end
    apb(1'b1, scf_pkg::ADDR_CLKCTL, 32'h6);
    repeat (scf_pkg::SWITCH_MAX_OSC) @(posedge pclk);
    rd(scf_pkg::ADDR_CLKCTL, 33'h26);
    ticks(0);
    apb(1'b1, scf_pkg::ADDR_CLKCTL, 32'h2);
    $display("test clock rate done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, scf_pkg::ADDR_IEN, 32'h10 | i);
      if (i < 5) ee[i] = 1'b1;
      rd(scf_pkg::ADDR_IEN, {1'b0, ee});
    end
    apb(1'b1, scf_pkg::ADDR_IEN, 32'h18);
    apb(1'b1, scf_pkg::ADDR_IEN, 32'h02);
    rd(scf_pkg::ADDR_IEN, 33'h11B);
    apb(1'b1, scf_pkg::ADDR_IEN, 32'h08);
    $display("test enables done");
    for (int i = 0; i < 4; i++) begin
      m = 5'(rnd());
      pulse({1'b0, m});
      ef = ef | m;
      rd(scf_pkg::ADDR_IRQF, {28'h0, ef});
      d = rnd();
      apb(1'b1, scf_pkg::ADDR_IRQF, d);
      ef = ef & d[4:0];
      rd(scf_pkg::ADDR_IRQF, {28'h0, ef});
    end
    pulse(6'h10);
    pulse(6'h20);
    ef[4] = 1'b0;
    rd(scf_pkg::ADDR_IRQF, {28'h0, ef});
    rd(scf_pkg::ADDR_IEN, 33'h1B);
    $display("test flags done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, scf_pkg::ADDR_STBCTL, (i == 0) ? 32'h4 : (i == 1) ? 32'h8 : 32'h0);
      apb(1'b1, scf_pkg::ADDR_CMD, 32'h1);
      rd(scf_pkg::ADDR_CMD, 33'h1);
      if (i == 2) begin
        wake_pin <= 1'b1;
        irq_release <= 1'b1;
        ticks(0);
        rd(scf_pkg::ADDR_CMD, 33'h1);
        pulse(6'h04);
        ef[2] = 1'b1;
      end else if (i == 0) begin
        wake_pin <= 1'b1;
      end else begin
        irq_release <= 1'b1;
      end
      wait_wake(1'b0);
      rd(scf_pkg::ADDR_CMD, 33'h0);
      rd(scf_pkg::ADDR_CLKCTL, 33'h22);
    end
    $display("test halt done");
    pulse(6'h0B);
    apb(1'b1, scf_pkg::ADDR_IEN, 32'h18);
    apb(1'b1, scf_pkg::ADDR_STBCTL, 32'h3);
    @(posedge pclk);
    apb(1'b1, scf_pkg::ADDR_CMD, 32'h1);
    rd(scf_pkg::ADDR_CMD, 33'h2);
    rd(scf_pkg::ADDR_IEN, 33'h100);
    rd(scf_pkg::ADDR_IRQF, 33'h0);
    ef = 5'h00;
    irq_release <= 1'b1;
    ticks(0);
    rd(scf_pkg::ADDR_CMD, 33'h2);
    wake_pin <= 1'b1;
    wait_wake(1'b0);
    rd(scf_pkg::ADDR_CMD, 33'h0);
    rd(scf_pkg::ADDR_CLKCTL, 33'h22);
    $display("test hold done");
    watchdog_option <= 1'b1;
    pulse(6'h04);
    apb(1'b1, scf_pkg::ADDR_STBCTL, 32'h0);
    apb(1'b1, scf_pkg::ADDR_CMD, 32'h1);
    pulse(6'h04);
    wait_wake(1'b1);
    watchdog_option <= 1'b0;
    rd(scf_pkg::ADDR_IRQF, 33'h04);
    apb(1'b1, scf_pkg::ADDR_IRQF, 32'h1B);
    rd(scf_pkg::ADDR_IRQF, 33'h0);
    $display("test watchdog done");
    repeat (4) @(posedge pclk);
    wrap_up();
  end
endmodule

`default_nettype wire
